// ---- rtl/nfam_top.sv ----
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
// Summary of operation
// R1: a file must be selected before file offsets translate to physical addresses; with no file the phys register still reads the message mapping
// R2: container file offset zero maps to physical 0x0180, bytes following
// R3: container byte at offset 0x0002 holds mapping version 0x20
// R4: container offsets 0x0009..0x000a hold file identifier 0x0103
// R5: container offsets 0x0003..0x0004 hold maximum read response length
// R6: container offsets 0x0005..0x0006 hold maximum write command length
// R7: message file offsets 0..1 map to physical 0x000c..0x000d, fixed size
// R8: message file offset 2 onward maps from physical 0x0010, skipping 0x000e..f
// R9: one command may span length and message fields across the gap
// R10: empty message file is length 0x0003 then bytes 0xd00000
// R11: no interrupt output of any kind
// R12: message file uses upper block 0 and blocks 1..23, container block 24
module nfam_top
  import nfam_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output logic      [8:0]   nvm_addr,
  output logic              nvm_valid,
  output logic              nvm_in_len
);
  // no interrupt logic exists in this block, see R11
  logic [1:0]  sel_reg;
  logic [15:0] fofs_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [8:0]  nvm_addr_reg;
  logic        nvm_valid_reg;
  logic        nvm_in_len_reg;

  wire logic        setup    = psel && !penable;
  // writes wait for the completing edge, so a transfer never lands half done
  wire logic        wr_acc   = psel && penable && pready_reg && pwrite;
  wire logic        hit_sel  = (paddr == NFAM_SEL_OFS);
  wire logic        hit_fofs = (paddr == NFAM_FOFS_OFS);
  wire logic        hit_phys = (paddr == NFAM_PHYS_OFS);
  wire logic        hit_stat = (paddr == NFAM_STAT_OFS);
  wire logic        hit_walk = (paddr == NFAM_WALK_OFS);
  wire logic        mapped   = hit_sel | hit_fofs | hit_phys | hit_stat | hit_walk;
  // selection codes other than the two files fall back to none, see R1
  wire logic [1:0]  sel_in   = (pwdata[1:0] == NFAM_SEL_CC || pwdata[1:0] == NFAM_SEL_NDEF)
                               ? pwdata[1:0] : NFAM_SEL_NONE;

  wire logic [8:0]  x_phys;
  wire logic        x_valid;
  wire logic        x_len;
  wire logic [8:0]  w_phys;
  wire logic        w_valid;
  wire logic        w_len;
  wire logic        w_busy;
  wire logic [15:0] w_fofs;
  wire logic        w_step;
  wire logic        walk_go  = wr_acc && hit_walk && (sel_reg != NFAM_SEL_NONE);

  nfam_xlate u_xlate
  (
    .sel    (sel_reg),
    .fofs   (fofs_reg),
    .phys   (x_phys),
    .valid  (x_valid),
    .in_len (x_len)
  );

  nfam_xlate u_wxlate
  (
    .sel    (sel_reg),
    .fofs   (w_fofs),
    .phys   (w_phys),
    .valid  (w_valid),
    .in_len (w_len)
  );

  nfam_walker u_walker
  (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (walk_go),
    .start_fofs (pwdata[15:0]),
    .count      (pwdata[23:16]),
    .busy       (w_busy),
    .cur_fofs   (w_fofs),
    .step       (w_step)
  );

  wire logic [31:0] rd_mux =
    hit_sel  ? {30'h0, sel_reg} :
    hit_fofs ? {16'h0, fofs_reg} :
    hit_phys ? {23'h0, x_phys} :
    hit_stat ? {29'h0, w_busy, x_len, x_valid} :
    hit_walk ? {16'h0, w_fofs} : 32'h0;

  // a walk streams one translated byte address per cycle to the array
  wire logic [8:0]  out_addr  = w_step ? w_phys  : x_phys;
  wire logic        out_valid = w_step ? w_valid : 1'b0;
  wire logic        out_len   = w_step ? w_len   : 1'b0;

  // apb: answer in the access cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      prdata_reg  <= (setup && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // writes land at the edge that completes the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg  <= NFAM_SEL_NONE;
      fofs_reg <= 16'h0000;
    end
    else
    begin
      if (wr_acc && hit_sel)
        sel_reg <= sel_in; // see R1
      if (wr_acc && hit_fofs)
        fofs_reg <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_addr_reg   <= 9'h000;
      nvm_valid_reg  <= 1'b0;
      nvm_in_len_reg <= 1'b0;
    end
    else
    begin
      nvm_addr_reg   <= out_addr; // see R2, R7, R8
      nvm_valid_reg  <= out_valid; // see R9
      nvm_in_len_reg <= out_len;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign nvm_addr   = nvm_addr_reg;
  assign nvm_valid  = nvm_valid_reg;
  assign nvm_in_len = nvm_in_len_reg;
endmodule

// ---- shared/nfam_pkg.sv ----
package nfam_pkg;
  localparam int          NFAM_ADDR_W       = 9;
  localparam int          NFAM_FOFS_W       = 16;
  // physical layout of the non-volatile array
  localparam logic [8:0]  NFAM_CC_BASE      = 9'h180;
  localparam logic [8:0]  NFAM_MLEN_BASE    = 9'h00c;
  localparam logic [8:0]  NFAM_MSG_BASE     = 9'h010;
  localparam logic [15:0] NFAM_MSG_FOFS     = 16'h0002;
  localparam logic [15:0] NFAM_CC_SIZE      = 16'h0010;
  localparam logic [15:0] NFAM_NDEF_SIZE    = 16'h0172;
  // container content expected from the preparing party
  localparam logic [15:0] NFAM_CC_VER_OFS   = 16'h0002;
  localparam logic [7:0]  NFAM_CC_VER_VAL   = 8'h20;
  localparam logic [15:0] NFAM_CC_FID_OFS   = 16'h0009;
  localparam logic [15:0] NFAM_CC_FID_VAL   = 16'h0103;
  localparam logic [15:0] NFAM_CC_MLE_OFS   = 16'h0003;
  localparam logic [15:0] NFAM_CC_MLC_OFS   = 16'h0005;
  // register map
  localparam logic [11:0] NFAM_SEL_OFS      = 12'h000;
  localparam logic [11:0] NFAM_FOFS_OFS     = 12'h004;
  localparam logic [11:0] NFAM_PHYS_OFS     = 12'h008;
  localparam logic [11:0] NFAM_STAT_OFS     = 12'h00c;
  localparam logic [11:0] NFAM_WALK_OFS     = 12'h010;

  typedef enum logic [1:0]
  {
    NFAM_SEL_NONE = 2'b00,
    NFAM_SEL_CC   = 2'b01,
    NFAM_SEL_NDEF = 2'b10
  } nfam_sel_e;
endpackage

// ---- rtl/nfam_xlate.sv ----
`timescale 1ns/1ps
module nfam_xlate
  import nfam_pkg::*;
(
  input  wire logic [1:0]              sel,
  input  wire logic [NFAM_FOFS_W-1:0]  fofs,
  output logic      [NFAM_ADDR_W-1:0]  phys,
  output logic                         valid,
  output logic                         in_len
);
  wire logic is_cc   = (sel == NFAM_SEL_CC);
  wire logic is_ndef = (sel == NFAM_SEL_NDEF);
  wire logic len_hit = (fofs < NFAM_MSG_FOFS);
  wire logic [15:0] cc_sum  = fofs + {7'h00, NFAM_CC_BASE};
  wire logic [15:0] len_sum = fofs + {7'h00, NFAM_MLEN_BASE};
  // skip physical bytes 0x00e..0x00f between length and message
  wire logic [15:0] msg_sum = fofs - NFAM_MSG_FOFS + {7'h00, NFAM_MSG_BASE};

  // see R2, R7, R8
  assign phys   = is_cc ? cc_sum[8:0] : (len_hit ? len_sum[8:0] : msg_sum[8:0]);
  // see R1, R12
  assign valid  = (is_cc && fofs < NFAM_CC_SIZE) || (is_ndef && fofs < NFAM_NDEF_SIZE);
  assign in_len = is_ndef && len_hit;
endmodule

// ---- rtl/nfam_walker.sv ----
`timescale 1ns/1ps
module nfam_walker
  import nfam_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    start,
  input  wire logic [NFAM_FOFS_W-1:0]  start_fofs,
  input  wire logic [7:0]              count,
  output logic                         busy,
  output logic      [NFAM_FOFS_W-1:0]  cur_fofs,
  output logic                         step
);
  logic [NFAM_FOFS_W-1:0] fofs_reg;
  logic [7:0]             left_reg;

  assign busy     = (left_reg != 8'h00);
  assign cur_fofs = fofs_reg;
  assign step     = busy;

  // one byte per cycle, so a command crosses the gap seamlessly
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fofs_reg <= 16'h0000;
      left_reg <= 8'h00;
    end
    else if (start && !busy)
    begin
      fofs_reg <= start_fofs;
      left_reg <= count;
    end
    else if (busy)
    begin
      fofs_reg <= fofs_reg + 16'h0001; // see R9
      left_reg <= left_reg - 8'h01;
    end
  end
endmodule

// ---- tb/nfam_chk_sva.sv ----
`timescale 1ns/1ps
module nfam_chk_sva
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [8:0]  nvm_addr,
  input wire logic        nvm_valid,
  input wire logic        nvm_in_len
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence len_end_s;
    nvm_valid && nvm_in_len && nvm_addr == 9'h00d;
  endsequence
  chk_setup_answer: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_len_place: assert property (nvm_in_len |-> nvm_valid && nvm_addr inside {9'h00c, 9'h00d})
    else $error("length byte misplaced");
  chk_len_follow: assert property (nvm_in_len && nvm_addr == 9'h00c ##1 nvm_valid |-> nvm_in_len && nvm_addr == 9'h00d)
    else $error("length field not two bytes");
  chk_gap_skip: assert property (nvm_valid |-> !(nvm_addr inside {9'h00e, 9'h00f}))
    else $error("gap byte addressed");
  chk_gap_cross: assert property (len_end_s ##1 nvm_valid |-> nvm_addr == 9'h010 && !nvm_in_len)
    else $error("gap not crossed");
  chk_msg_step: assert property (nvm_valid && !nvm_in_len ##1 nvm_valid |-> nvm_addr == $past(nvm_addr) + 9'h001)
    else $error("message bytes not consecutive");
  chk_file_range: assert property (nvm_valid |-> nvm_addr >= 9'h00c && nvm_addr <= 9'h18f)
    else $error("address outside files");
endmodule
bind nfam_top nfam_chk_sva u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .nvm_addr, .nvm_valid, .nvm_in_len);

// ---- tb/nfam_reader.sv ----
`timescale 1ns/1ps
module nfam_reader
(
  input  wire logic         pclk,
  input  wire logic         pready,
  input  wire logic [8:0]   nvm_addr,
  input  wire logic         nvm_valid,
  output logic              psel,
  output logic              penable,
  output logic              pwrite,
  output logic      [11:0]  paddr,
  output logic      [31:0]  pwdata
);
  logic [7:0] mem [512];
  logic [7:0] img [$];
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // prepared bytes land wherever the tag steers each walked byte
  always @(posedge pclk)
  begin
    if (nvm_valid && img.size() > 0)
      mem[nvm_addr] <= img.pop_front();
  end
  // the caller selects a file before offsets mean anything, except in the no file test
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (!pready && n < 20);
    if (!pready)
    begin
      $display("Error pready expected 1 seen 0");
      tb_top.fail_count++;
      tb_top.conclude();
    end
    {psel, penable} <= 2'b00;
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import nfam_pkg::*;
();
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
  logic nvm_valid, nvm_in_len;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0] nvm_addr;
  logic [32:0] rq[$];
  logic [9:0] nq[$];
  int fail_count = 0, num_checks = 0, o;
  always #5 pclk = ~pclk;
  nfam_reader rdr (.pclk, .pready, .nvm_addr, .nvm_valid, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  nfam_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .nvm_addr, .nvm_valid, .nvm_in_len);
  task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic rd(logic [11:0] a, logic [32:0] e);
    rq.push_back(e);
    rdr.xfer(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk)
  begin
    if (pready && !pwrite)
      chk("read", rq.size() ? rq.pop_front() : 'x, {pslverr, prdata});
    if (nvm_valid)
      chk("nvm", nq.size() ? nq.pop_front() : 'x, {nvm_in_len, nvm_addr});
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(29));
    rdr.xfer(1'b1, NFAM_FOFS_OFS, 32'h1);
    rd(NFAM_STAT_OFS, 33'h0);
    rdr.xfer(1'b1, NFAM_WALK_OFS, 32'h0003_0000);
    rd(12'hff0, {1'b1, 32'h0});
    rdr.xfer(1'b1, NFAM_SEL_OFS, 32'h3);
    rd(NFAM_SEL_OFS, 33'h0);
    $display("test no file done");
    rdr.xfer(1'b1, NFAM_SEL_OFS, 32'h1);
    repeat (4)
    begin
      o = $urandom % 16;
      rdr.xfer(1'b1, NFAM_FOFS_OFS, o);
      rd(NFAM_PHYS_OFS, 33'h180 + o);
    end
    rdr.img = '{8'h00, 8'h0f, NFAM_CC_VER_VAL, 8'h00, 8'h3b, 8'h00, 8'h34, 8'h04, 8'h06,
      NFAM_CC_FID_VAL[15:8], NFAM_CC_FID_VAL[7:0]};
    for (int k = 0; k < 11; k++)
      nq.push_back({1'b0, NFAM_CC_BASE + k[8:0]});
    rdr.xfer(1'b1, NFAM_WALK_OFS, 32'h000b_0000);
    for (int n = 0; n < 30 && nq.size(); n++)
      @(posedge pclk);
    @(posedge pclk);
    chk("cc walk left", 33'h0, nq.size());
    chk("cc version", NFAM_CC_VER_VAL, rdr.mem[9'h182]);
    chk("cc file id", NFAM_CC_FID_VAL, {rdr.mem[9'h189], rdr.mem[9'h18a]});
    chk("cc max read", 16'h003b, {rdr.mem[9'h183], rdr.mem[9'h184]});
    chk("cc max write", 16'h0034, {rdr.mem[9'h185], rdr.mem[9'h186]});
    $display("test container done");
    rdr.xfer(1'b1, NFAM_SEL_OFS, 32'h2);
    for (int i = 0; i < 6; i++)
    begin
      o = i < 3 ? i : 2 + $urandom % 16'h170;
      rdr.xfer(1'b1, NFAM_FOFS_OFS, o);
      rd(NFAM_PHYS_OFS, o < 2 ? 33'h00c + o : 33'h00e + o);
      rd(NFAM_STAT_OFS, o < 2 ? 33'h3 : 33'h1);
    end
    rdr.xfer(1'b1, NFAM_FOFS_OFS, 32'h172);
    rd(NFAM_STAT_OFS, 33'h0);
    nq = '{10'h20c, 10'h20d, 10'h010, 10'h011, 10'h012};
    rdr.img = '{8'h00, 8'h03, 8'hd0, 8'h00, 8'h00};
    rdr.xfer(1'b1, NFAM_WALK_OFS, 32'h0005_0000);
    rd(NFAM_STAT_OFS, 33'h4);
    for (int n = 0; n < 30 && nq.size(); n++)
      @(posedge pclk);
    @(posedge pclk);
    chk("walk left", 33'h0, nq.size());
    chk("length field", 16'h0003, {rdr.mem[9'h00c], rdr.mem[9'h00d]});
    chk("empty message", 24'hd00000, {rdr.mem[9'h010], rdr.mem[9'h011], rdr.mem[9'h012]});
    rd(NFAM_WALK_OFS, 33'h5);
    $display("test message file done");
    conclude();
  end
  initial
  begin
    #200000;
    $display("Error timeout expected done seen hang");
    fail_count++;
    conclude();
  end
endmodule
